/* File: logic/usart_aux_regs.svh */
// Constants for the serial unit auxiliary modes block.
// Included by the package and the design; definitions only.
`ifndef USART_AUX_REGS_SVH
`define USART_AUX_REGS_SVH
`define LDM_OFF        2'h0
`define LDM_EXTERNAL   2'h1
`define LDM_TXCONTROL  2'h2
`define OSR_NORMAL     5'h10
`define OSR_DOUBLE     5'h08
`define BAUD_W         16
`define SLEEP_ACTIVE   2'h0
`define SLEEP_IDLE     2'h1
`define SLEEP_STANDBY  2'h2
`define SLEEP_PDOWN    2'h3
`endif

/* File: logic/usart_aux_pkg.sv */
// Types for the serial unit auxiliary modes block.
// Assumes the constants header sits beside it.
`include "usart_aux_regs.svh"
package usart_aux_pkg;
  typedef enum logic [1:0] {MODE_ASYNC, MODE_SPI_MASTER} op_mode_t;
  typedef struct packed {
    logic txEnable;
    logic rxEnable;
    logic spiMaster;
    logic clockPhaseSelect;
    logic dataOrderSelect;
    logic doubleSpeedSelect;
    logic [1:0] lineDriverMode;
    logic startFrameDetectEnable;
    logic rxcIntEnable;
    logic rxsIntEnable;
  } ctrl_t;
  typedef struct packed {
    logic receiveCompleteFlag;
    logic startDetectFlag;
    logic transmitCompleteFlag;
    logic dataEmptyFlag;
    logic frameError;
  } status_t;
endpackage

/* File: logic/usart_aux.sv */
// Serial unit: async frames, master SPI, line driver enable, start detect wake.
// Assumes one clock, synchronous inputs, control bits as plain ports.
// Summary of operation
// - SPI master drives sync clock from baud
// - Data write starts every SPI transfer
// - Buffer loads shifter only when shifter ready
// - SPI flags as async; errors read zero
// - Disabling in SPI equals async disabling
// - Phase and order select match SPI
// - No collision detect, no double speed SPI
// - Output MOSI, input MISO, no select
// - Mode 1 external driver, 2 TX control
// - Enable output high while async transmitter active, low in SPI
// - Enable rises one baud tick early
// - Enable held through the single stop bit
// - Start detect only async Standby, enabled
// - Falling edge powers oscillator, enables clock
// - False start switches clock back off
// - Standby start sets start detect flag
// - Active, Idle, PowerDown disable start detect
// - Receive and start flags share interrupt
// - Wake behaviour follows interrupt enables
// - Sixteen or eight samples per bit
`include "usart_aux_regs.svh"
`timescale 1ns/1ns
module usart_aux
  import usart_aux_pkg::*;
#(
  parameter int DATA_W = 8
)(
  // Clock, reset, enable
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              clkEn,
  // Control
  input  wire ctrl_t             ctrl,
  input  wire logic [`BAUD_W-1:0] baudDiv,
  input  wire logic [1:0]        sleepMode,
  // Data
  input  wire logic              dataWrite,
  input  wire logic [DATA_W-1:0] dataIn,
  input  wire logic              dataRead,
  input  wire logic              flagClear,
  output logic [DATA_W-1:0]      dataOut,
  output status_t                status,
  output logic                   interruptReq,
  // Pins and power
  input  wire logic              rxPin,
  output logic                   txPin,
  output logic                   txPinOe,
  output logic                   sync_clock_pin,
  output logic                   transmit_enable_out,
  output logic                   oscRequest,
  output logic                   wakeReq
);
  localparam int CW = $clog2(DATA_W + 4);
  logic [`BAUD_W-1:0] baudCnt;     // Baud divider
  logic               tick;        // Sample tick
  logic [4:0]         txSub;       // Samples within a tx bit
  logic               txBit;       // Bit boundary
  logic [DATA_W-1:0]  txBuf;       // Transmit buffer
  logic               txBufFull;   // Buffer holds a word
  logic [DATA_W+1:0]  txShift;     // Frame shifter
  logic [CW-1:0]      txCnt;       // Bits remaining
  logic               txBusy;      // Frame in progress
  logic               txLead;      // Guard tick before first bit
  logic               sckPhase;    // SPI half period
  logic [DATA_W-1:0]  rxShift;     // Receive shifter
  logic [CW-1:0]      rxCnt;       // Bits received
  logic               rxBusy;      // Receiving
  logic [4:0]         rxSub;       // Samples within rx bit
  logic [2:0]         vote;        // Majority window
  logic               rxPrev;      // Last rx level
  logic               sfdArmed;    // Start detect active
  logic [4:0]         osr;         // Samples per bit
  logic               spi;         // SPI master mode
  logic               ldmOn;       // Line driver mode on
  logic               majority;    // Voted bit

  assign spi      = ctrl.spiMaster;
  assign osr      = ctrl.doubleSpeedSelect ? `OSR_DOUBLE : `OSR_NORMAL;
  assign ldmOn    = (ctrl.lineDriverMode == `LDM_EXTERNAL) ||
                    (ctrl.lineDriverMode == `LDM_TXCONTROL);
  assign majority = (vote[0] & vote[1]) | (vote[1] & vote[2]) | (vote[0] & vote[2]);
  assign txBit    = tick && (txSub == osr - 5'h01);
  // Start detect only in async Standby with enable set
  assign sfdArmed = ctrl.startFrameDetectEnable && !spi &&
                    (sleepMode == `SLEEP_STANDBY);

  // Baud generator, sample tick; SPI uses it directly for clock edges
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      baudCnt <= '0;
      tick    <= 1'b0;
    end
    else if (clkEn)
    begin
      tick <= (baudCnt == 0);
      if (baudCnt == 0)
        baudCnt <= baudDiv;
      else
        baudCnt <= baudCnt - 1'b1;
    end
  end

  // Transmit buffer: write loads it, shifter takes it when idle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      txBuf     <= '0;
      txBufFull <= 1'b0;
    end
    else if (clkEn)
    begin
      if (dataWrite && !txBufFull && ctrl.txEnable)
      begin
        txBuf     <= dataIn;
        txBufFull <= 1'b1;
      end
      else if (txBufFull && !txBusy && !txLead)
        txBufFull <= 1'b0;
    end
  end

  // Transmit shifter for both async frames and SPI master
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      txShift  <= '1;
      txCnt    <= '0;
      txBusy   <= 1'b0;
      txLead   <= 1'b0;
      txSub    <= '0;
      sckPhase <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!txBusy && !txLead && txBufFull)
      begin
        txLead <= !spi && ldmOn;
        txBusy <= spi || !ldmOn;
        txSub  <= '0;
        sckPhase <= 1'b0;
        if (spi)
        begin
          // Order select: LSB first when set, else MSB first
          txShift <= {2'b11, ctrl.dataOrderSelect ? txBuf :
                      {<<{txBuf}}};
          txCnt   <= CW'(DATA_W);
        end
        else
        begin
          txShift <= {1'b1, txBuf, 1'b0};
          txCnt   <= CW'(DATA_W + 2);
        end
      end
      else if (txLead && tick)
      begin
        txLead <= 1'b0; // Guard tick spent
        txBusy <= 1'b1;
      end
      else if (txBusy && spi && tick)
      begin
        // Each tick is one half period of the sync clock
        sckPhase <= !sckPhase;
        if (sckPhase)
        begin
          txShift <= {1'b1, txShift[DATA_W+1:1]};
          txCnt   <= txCnt - 1'b1;
          if (txCnt == 1)
            txBusy <= 1'b0;
        end
      end
      else if (txBusy && !spi && tick)
      begin
        txSub <= txBit ? 5'h00 : txSub + 5'h01;
        if (txBit)
        begin
          txShift <= {1'b1, txShift[DATA_W+1:1]};
          txCnt   <= txCnt - 1'b1;
          if (txCnt == 1)
            txBusy <= 1'b0;
        end
      end
    end
  end

  // Pin outputs: tx pin is MOSI in SPI mode
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      txPin               <= 1'b1;
      txPinOe             <= 1'b0;
      sync_clock_pin      <= 1'b0;
      transmit_enable_out <= 1'b0;
    end
    else if (clkEn)
    begin
      // Line stays idle through the guard tick so the enable leads the start bit
      txPin   <= txLead ? 1'b1 : txShift[0];
      txPinOe <= ctrl.txEnable || txBusy || txBufFull;
      // Phase select 0 samples first edge, 1 shifts first edge
      sync_clock_pin <= spi && txBusy &&
                        (sckPhase ^ ctrl.clockPhaseSelect) && (txCnt != 0);
      transmit_enable_out <= ldmOn && !spi && (txLead || txBusy);
    end
  end

  // Receiver: 3 centre samples voted, or SPI sample on clock edge
  always_ff @(posedge clk_sys)
  begin
    if (rst || !ctrl.rxEnable)
    begin
      rxBusy  <= 1'b0;
      rxCnt   <= '0;
      rxSub   <= '0;
      vote    <= 3'h7;
      rxShift <= '0;
      rxPrev  <= 1'b1;
    end
    else if (clkEn)
    begin
      rxPrev <= rxPin;
      if (spi)
      begin
        if (txBusy && tick && !sckPhase)
          rxShift <= ctrl.dataOrderSelect ? {rxPin, rxShift[DATA_W-1:1]}
                                          : {rxShift[DATA_W-2:0], rxPin};
      end
      else if (!rxBusy && rxPrev && !rxPin)
      begin
        rxBusy <= 1'b1;
        rxSub  <= '0;
        rxCnt  <= '0;
      end
      else if (rxBusy && tick)
      begin
        rxSub <= (rxSub == osr - 5'h01) ? 5'h00 : rxSub + 5'h01;
        if (rxSub >= (osr >> 1) - 5'h01 && rxSub <= (osr >> 1) + 5'h01)
          vote <= {vote[1:0], rxPin};
        if (rxSub == osr - 5'h01)
        begin
          rxCnt <= rxCnt + 1'b1;
          if (rxCnt == 0 && majority)
            rxBusy <= 1'b0; // False start rejected
          else if (rxCnt >= 1 && rxCnt <= CW'(DATA_W))
            rxShift <= {majority, rxShift[DATA_W-1:1]};
          else if (rxCnt == CW'(DATA_W + 1))
            rxBusy <= 1'b0;
        end
      end
    end
  end

  // Status flags; hardware set wins over clear
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      status  <= '0;
      dataOut <= '0;
    end
    else if (clkEn)
    begin
      status.dataEmptyFlag <= !txBufFull;
      status.frameError    <= 1'b0;
      if (!spi && rxBusy && tick && rxSub == osr - 5'h01 && rxCnt == CW'(DATA_W + 1))
      begin
        status.receiveCompleteFlag <= 1'b1;
        dataOut <= rxShift;
      end
      else if (spi && txBusy && tick && sckPhase && txCnt == 1 && ctrl.rxEnable)
      begin
        status.receiveCompleteFlag <= 1'b1;
        dataOut <= rxShift;
      end
      else if (dataRead)
        status.receiveCompleteFlag <= 1'b0;
      if (txBusy && tick && txCnt == 1 && !txBufFull && (spi ? sckPhase : txBit))
        status.transmitCompleteFlag <= 1'b1;
      else if (flagClear)
        status.transmitCompleteFlag <= 1'b0;
      if (sfdArmed && rxPrev && !rxPin)
        status.startDetectFlag <= 1'b1;
      else if (flagClear)
        status.startDetectFlag <= 1'b0;
    end
  end

  // Shared interrupt, oscillator request, wake request
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      interruptReq <= 1'b0;
      oscRequest   <= 1'b0;
      wakeReq      <= 1'b0;
    end
    else if (clkEn)
    begin
      interruptReq <= (status.receiveCompleteFlag && ctrl.rxcIntEnable) ||
                      (status.startDetectFlag && ctrl.rxsIntEnable);
      oscRequest   <= sfdArmed && ((rxPrev && !rxPin) || rxBusy);
      wakeReq      <= sfdArmed &&
                      ((ctrl.rxsIntEnable && status.startDetectFlag) ||
                       (ctrl.rxcIntEnable && status.receiveCompleteFlag));
    end
  end

  property p_ldm_low;
    @(posedge clk_sys) disable iff (rst)
    !ldmOn |=> !transmit_enable_out;
  endproperty
  a_ldm_low: assert property (p_ldm_low) else $error("enable high outside mode");

  property p_lead;
    @(posedge clk_sys) disable iff (rst)
    (txLead && clkEn) |=> transmit_enable_out;
  endproperty
  a_lead: assert property (p_lead) else $error("enable late");

  property p_frame;
    @(posedge clk_sys) disable iff (rst)
    (txBusy && ldmOn && !spi && clkEn) |=> transmit_enable_out;
  endproperty
  a_frame: assert property (p_frame) else $error("enable dropped in frame");

  property p_ferr;
    @(posedge clk_sys) disable iff (rst)
    spi |=> !status.frameError;
  endproperty
  a_ferr: assert property (p_ferr) else $error("error flag set");

  property p_sfd;
    @(posedge clk_sys) disable iff (rst)
    (sleepMode != `SLEEP_STANDBY) && !status.startDetectFlag && clkEn
      |=> !status.startDetectFlag;
  endproperty
  a_sfd: assert property (p_sfd) else $error("start detect outside standby");

  property p_sck;
    @(posedge clk_sys) disable iff (rst)
    !spi |=> !sync_clock_pin;
  endproperty
  a_sck: assert property (p_sck) else $error("clock outside spi");

  property p_irq;
    @(posedge clk_sys) disable iff (rst)
    (clkEn && status.startDetectFlag && ctrl.rxsIntEnable) |=> interruptReq;
  endproperty
  a_irq: assert property (p_irq) else $error("shared interrupt missing");

  property p_load;
    @(posedge clk_sys) disable iff (rst)
    (clkEn && txBusy && txBufFull) |=> txBufFull;
  endproperty
  a_load: assert property (p_load) else $error("buffer moved while busy");
endmodule

/* File: verification/remote_uart_model.sv */
// Far end of the serial line: a remote transmitter and a line driver.
// Assumes the system clock is shared and the bit length in clocks is given.
`timescale 1ns/1ns
module remote_uart_model
(
  // Clock and bit timing
  input  wire logic        clk_sys,
  input  wire logic [15:0] bitCyc,
  // Device side pins
  input  wire logic        txPin,
  input  wire logic        transmit_enable_out,
  output logic             rxPin,
  // Level that other stations see on the bus
  output logic             busLevel
);
  // Driver passes data only while enabled; bias holds the bus idle high
  assign busLevel = transmit_enable_out ? txPin : 1'b1;

  // Idle line is high
  initial rxPin = 1'b1;

  // One frame: start, eight bits LSB first, one stop, at the exact rate
  task automatic sendFrame(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    @(posedge clk_sys);
    for (int i = 0; i < 10; i++)
    begin
      rxPin <= f[i];
      repeat (bitCyc) @(posedge clk_sys);
    end
  endtask

  // Short low spike that a receiver must reject
  task automatic glitch();
    @(posedge clk_sys);
    rxPin <= 1'b0;
    repeat (bitCyc / 8) @(posedge clk_sys);
    rxPin <= 1'b1;
    repeat (2 * bitCyc) @(posedge clk_sys);
  endtask
endmodule

/* File: verification/test_usart_spi_line_driver_mode_startframe.sv */
// Self-checking bench for the serial unit auxiliary modes.
// Assumes the design package and the remote line model compile first.
`include "usart_aux_regs.svh"
`timescale 1ns/1ns
module test_usart_spi_line_driver_mode_startframe;
  import usart_aux_pkg::*;
  // Design connections
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic               clkEn = 1'b1;
  ctrl_t              ctrl = '0;
  logic [`BAUD_W-1:0] baudDiv = 16'h0001;
  logic [1:0]         sleepMode = `SLEEP_ACTIVE;
  logic               dataWrite = 1'b0;
  logic [7:0]         dataIn = 8'h00;
  logic               dataRead = 1'b0;
  logic               flagClear = 1'b0;
  logic [7:0]         dataOut;
  status_t            status;
  logic               interruptReq, rxPin, txPin, txPinOe, sync_clock_pin;
  logic               transmit_enable_out, oscRequest, wakeReq, busLevel;
  // Bench state
  int                 n_mismatch = 0, compares = 0, n, edges;
  int                 seed = 32'h2c6d4488;
  logic [31:0]        r;
  ctrl_t              cfg = '0;
  logic [15:0]        bitc = 16'h0020;
  logic [7:0]         cap;

  // System clock
  always #20 clk_sys = ~clk_sys;

  usart_aux #(.DATA_W(8)) i_usart_aux (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn),
    .ctrl(ctrl), .baudDiv(baudDiv), .sleepMode(sleepMode), .dataWrite(dataWrite),
    .dataIn(dataIn), .dataRead(dataRead), .flagClear(flagClear), .dataOut(dataOut),
    .status(status), .interruptReq(interruptReq), .rxPin(rxPin), .txPin(txPin),
    .txPinOe(txPinOe), .sync_clock_pin(sync_clock_pin),
    .transmit_enable_out(transmit_enable_out), .oscRequest(oscRequest), .wakeReq(wakeReq));
  remote_uart_model i_remote_uart_model (.clk_sys(clk_sys), .bitCyc(bitc), .txPin(txPin),
    .transmit_enable_out(transmit_enable_out), .rxPin(rxPin), .busLevel(busLevel));

  // Compare and report
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Bit reversal of a byte
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      rev[i] = v[7 - i];
  endfunction

  // Control levels and bit length in clocks
  task automatic apply(input logic [1:0] s);
    @(posedge clk_sys);
    ctrl <= cfg;
    sleepMode <= s;
    bitc <= (baudDiv + 16'h0001) * (cfg.doubleSpeedSelect ? 16'h0008 : 16'h0010);
  endtask

  // Data write once the buffer reports empty
  task automatic write(input logic [7:0] v);
    n = 0;
    while (status.dataEmptyFlag !== 1'b1 && n < 2000)
    begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    dataWrite <= 1'b1;
    dataIn <= v;
    @(posedge clk_sys);
    dataWrite <= 1'b0;
  endtask

  // One-cycle read or flag clear pulse
  task automatic strobe(input logic rd);
    @(posedge clk_sys);
    dataRead <= rd;
    flagClear <= !rd;
    @(posedge clk_sys);
    dataRead <= 1'b0;
    flagClear <= 1'b0;
  endtask

  // Async frame out, watching the enable output around it
  task automatic txFrame(input logic [1:0] m, input logic ds, input logic [7:0] v);
    logic [9:0] f;
    logic       teLast;
    f = {1'b1, v, 1'b0};
    cfg = '0;
    cfg.txEnable = 1'b1;
    cfg.lineDriverMode = m;
    cfg.doubleSpeedSelect = ds;
    apply(`SLEEP_ACTIVE);
    write(v);
    n = 0;
    teLast = 1'b0;
    @(negedge clk_sys);
    while (txPin !== 1'b0 && n < 1000)
    begin
      teLast = transmit_enable_out;
      @(negedge clk_sys);
      n++;
    end
    check("enable lead", m != 2'h0, teLast);
    check("tx drive", 1'b1, txPinOe);
    repeat (bitc / 2) @(negedge clk_sys);
    for (int i = 0; i < 10; i++)
    begin
      check("tx bit", f[i], txPin);
      check("enable in frame", m != 2'h0, transmit_enable_out);
      check("bus level", f[i] | (m == 2'h0), busLevel);
      repeat (bitc) @(negedge clk_sys);
    end
    check("enable after", 1'b0, transmit_enable_out);
    check("tx complete", 1'b1, status.transmitCompleteFlag);
    strobe(1'b0);
  endtask

  // Async frame in at the chosen speed
  task automatic rxFrame(input logic ds, input logic [7:0] v);
    cfg = '0;
    cfg.rxEnable = 1'b1;
    cfg.rxcIntEnable = 1'b1;
    cfg.doubleSpeedSelect = ds;
    apply(`SLEEP_ACTIVE);
    i_remote_uart_model.sendFrame(v);
    repeat (4) @(negedge clk_sys);
    check("rx data", v, dataOut);
    check("rx complete", 1'b1, status.receiveCompleteFlag);
    check("rx irq", 1'b1, interruptReq);
    strobe(1'b1);
    repeat (2) @(negedge clk_sys);
    check("rx irq off", 1'b0, interruptReq);
  endtask

  // Start detection in one sleep mode
  task automatic wakeScan(input logic [1:0] s, input logic [7:0] v);
    cfg = '0;
    cfg.rxEnable = 1'b1;
    cfg.startFrameDetectEnable = 1'b1;
    cfg.rxsIntEnable = 1'b1;
    apply(s);
    fork
      i_remote_uart_model.sendFrame(v);
      begin
        repeat (bitc) @(negedge clk_sys);
        check("osc", s == `SLEEP_STANDBY, oscRequest);
      end
    join
    check("start flag", s == `SLEEP_STANDBY, status.startDetectFlag);
    check("start irq", s == `SLEEP_STANDBY, interruptReq);
    check("wake", s == `SLEEP_STANDBY, wakeReq);
    strobe(1'b0);
    strobe(1'b1);
  endtask

  // Master transfer, capturing the output on the sampling clock edge
  task automatic spiFrame(input logic ph, input logic od, input logic [7:0] v);
    logic sckLast;
    cfg = '0;
    cfg.txEnable = 1'b1;
    cfg.rxEnable = 1'b1;
    cfg.spiMaster = 1'b1;
    cfg.clockPhaseSelect = ph;
    cfg.dataOrderSelect = od;
    apply(`SLEEP_ACTIVE);
    edges = 0;
    sckLast = sync_clock_pin;
    repeat (64)
    begin
      @(negedge clk_sys);
      edges += (sync_clock_pin !== sckLast);
      sckLast = sync_clock_pin;
    end
    check("idle clock", 0, edges);
    write(v);
    n = 0;
    while (status.transmitCompleteFlag !== 1'b1 && n < 2000)
    begin
      @(negedge clk_sys);
      n++;
      if (sync_clock_pin !== sckLast && sync_clock_pin === !ph)
      begin
        edges++;
        cap = {cap[6:0], txPin};
      end
      sckLast = sync_clock_pin;
    end
    check("clock edges", 8, edges);
    check("out bits", od ? rev(v) : v, cap);
    check("error", 1'b0, status.frameError);
    check("spi rx", 8'hFF, dataOut);
    strobe(1'b0);
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check("enable reset", 1'b0, transmit_enable_out);
    check("status reset", 0, status);
    for (int m = 0; m < 3; m++)
      for (int d = 0; d < 2; d++)
      begin
        r = $random(seed);
        txFrame(m[1:0], d[0], r[7:0]);
      end
    for (int d = 0; d < 2; d++)
    begin
      r = $random(seed);
      rxFrame(d[0], r[7:0]);
    end
    for (int s = 0; s < 4; s++)
    begin
      r = $random(seed);
      wakeScan(s[1:0], r[7:0]);
    end
    apply(`SLEEP_STANDBY);
    i_remote_uart_model.glitch();
    check("osc after spike", 1'b0, oscRequest);
    for (int k = 0; k < 4; k++)
    begin
      r = $random(seed);
      spiFrame(k[1], k[0], r[7:0]);
    end
    summarize();
  end

  // Hang guard
  initial
  begin
    #(40 * 40000);
    n_mismatch++;
    summarize();
  end
endmodule
